// ===== rtl/cct_timer.sv
// 16-bit compare/capture timer channel with plain register port
// assumes a single 50 MHz clock; pins arrive asynchronously
//
// Functional notes
// - capture mode 100/101 clears the counter on capture_input_b rising edge.
// - counter rollover past maximum sets overflow status and, when masked in, raises the match interrupt.
// - two compare registers, each with an equality comparator.
// - double buffering off after reset; control bit 2 turns it on.
// - buffered values load into both compares on compare-one match.
// - while stopped, compare writes go straight to active values.
// - writing 0 to software capture bit latches counter into capture zero.
// - snapshot read while counting captures live count; stopped keeps last.
// - either comparator match raises the match interrupt.
// - toggle flip-flop inverts on matches and captures, each separately enabled.
// - command 00 inverts, 01 sets, 10 clears the toggle flip-flop.
// - toggle flip-flop drives the timer output pin.
// - each capture register raises its own capture interrupt on latch.
// - clock select 000 counts rising edges of the timer input pin.
// - selects 001..111 use prescaler taps; compare one sets the period.
// - trigger start waits for selected timer input edge before counting.
// - mask bits overflow, match1, match0 gate the match interrupt.
// - run bits 11 start prescaler and counter; 00 stops both.
// - capture mode 000 disables all hardware captures.
// - channel enable bit gates all timer operation except software toggle flip-flop commands.
// - the up-counter is sixteen bits wide.
// - clearing counter run stops and zeroes the counter.
// - clear-on-match zeroes the counter after compare-one match.
`timescale 1ns/1ps
`include "cct_params.svh"
module cct_timer
  import cct_pkg::*;
#(
  parameter int CW = 16,
  parameter int PW = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_timer_input_pin,
  input wire logic i_capture_input_b,
  output logic o_timer_output_pin,
  output logic o_match_interrupt,
  output logic o_capture0_interrupt,
  output logic o_capture1_interrupt
);

  // ****************************************
  // prescaler tap decode
  // ****************************************
  function automatic logic tap_hit(input logic [2:0] sel,
                                   input logic [PW-1:0] c);
    logic hit;
    hit = 1'b0;
    case (sel)
      3'h1: hit = 1'b1;
      3'h2: hit = &c[1:0];
      3'h3: hit = &c[3:0];
      3'h4: hit = &c[4:0];
      3'h5: hit = &c[5:0];
      3'h6: hit = &c[6:0];
      3'h7: hit = &c[7:0];
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ****************************************
  // storage
  // ****************************************
  logic en_r;
  logic prun_r;
  logic crun_r;
  logic tsel_r;
  logic tedge_r;
  logic dbuf_r;
  logic [7:0] mod_r;
  logic [3:0] ffen_r;
  logic [2:0] st_r;
  logic [2:0] im_r;
  logic [CW-1:0] uc_r;
  logic [CW-1:0] uc_nxt;
  logic [CW-1:0] snap_r;
  logic [CW-1:0] cmp0_r;
  logic [CW-1:0] cmp1_r;
  logic [CW-1:0] buf0_r;
  logic [CW-1:0] buf1_r;
  logic [CW-1:0] cp0_r;
  logic [CW-1:0] cp1_r;
  logic [PW-1:0] pre_r;
  logic ff_r;
  logic ff_d_r;
  logic ff_nxt;
  logic fresh_r;
  logic [31:0] rdata_r;
  logic mi_r;
  logic ci0_r;
  logic ci1_r;
  cct_state_t state_r;
  cct_state_t state_nxt;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pin_in;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] lvl_r;
  logic [1:0] lvl_d_r;
  assign pin_in = {i_capture_input_b, i_timer_input_pin};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          lvl_r[g] <= 1'b0;
          lvl_d_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= pin_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          // change accepted only once two stages agree
          if (s2_r[g] == s3_r[g]) begin
            lvl_r[g] <= s3_r[g];
          end
          lvl_d_r[g] <= lvl_r[g];
        end
      end
    end
  endgenerate

  wire in_rise = lvl_r[0] & ~lvl_d_r[0];
  wire in_fall = ~lvl_r[0] & lvl_d_r[0];
  wire b_rise = lvl_r[1] & ~lvl_d_r[1];
  wire ff_rise = ff_r & ~ff_d_r;
  wire ff_fall = ~ff_r & ff_d_r;

  // ****************************************
  // register decode
  // ****************************************
  wire wr_en = i_wr && (i_addr == `CCT_A_EN);
  wire wr_run = i_wr && (i_addr == `CCT_A_RUN);
  wire wr_cr = i_wr && (i_addr == `CCT_A_CR);
  wire wr_mod = i_wr && (i_addr == `CCT_A_MOD);
  wire wr_ffcr = i_wr && (i_addr == `CCT_A_FFCR);
  wire wr_im = i_wr && (i_addr == `CCT_A_IM);
  wire wr_rg0 = i_wr && (i_addr == `CCT_A_RG0);
  wire wr_rg1 = i_wr && (i_addr == `CCT_A_RG1);
  wire rd_st = i_rd && (i_addr == `CCT_A_ST);
  wire rd_uc = i_rd && (i_addr == `CCT_A_UC);
  wire [2:0] clk_sel = mod_r[2:0];
  wire cle = mod_r[`CCT_B_CLE];
  wire [2:0] cpm = mod_r[6:4];
  wire [1:0] ff_cmd = i_wdata[1:0];

  // ****************************************
  // run control
  // ****************************************
  wire counting = en_r && (state_r == CCT_COUNT);
  wire trig_edge = tedge_r ? in_fall : in_rise;
  wire go_count = (state_r != CCT_COUNT) && (state_nxt == CCT_COUNT);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CCT_IDLE: begin
        if (en_r && crun_r) begin
          state_nxt = tsel_r ? CCT_WAIT : CCT_COUNT;
        end
      end
      CCT_WAIT: begin
        if (!crun_r || !en_r) begin
          state_nxt = CCT_IDLE;
        end else if (trig_edge) begin
          state_nxt = CCT_COUNT;
        end
      end
      CCT_COUNT: begin
        if (!crun_r || !en_r) begin
          state_nxt = CCT_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // prescaler and source clock
  // ****************************************
  wire pre_go = en_r && prun_r;
  wire pre_tick = pre_go && tap_hit(clk_sel, pre_r);
  // external source ignores the prescaler run bit
  wire ext_tick = (clk_sel == `CCT_CLK_EXT) && in_rise;
  wire tick = counting && (ext_tick || pre_tick);

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pre_r <= '0;
    end else if (pre_go) begin
      pre_r <= pre_r + 1'b1;
    end else begin
      pre_r <= '0;
    end
  end

  // ****************************************
  // comparators and counter
  // ****************************************
  wire eq0 = (uc_r == cmp0_r);
  wire eq1 = (uc_r == cmp1_r);
  // one match per new count value, not per clock
  wire mt0 = counting && fresh_r && eq0;
  wire mt1 = counting && fresh_r && eq1;
  wire clr_b = en_r && b_rise &&
               (cpm == `CCT_CPM_CLR0 || cpm == `CCT_CPM_CLR1);
  wire clr_m = cle && eq1;
  wire of_ev = tick && !clr_m && (uc_r == `CCT_UC_MAX);

  always_comb begin
    uc_nxt = uc_r;
    if (!crun_r) begin
      uc_nxt = '0;
    end else if (clr_b) begin
      uc_nxt = '0;
    end else if (tick) begin
      // wraps to zero past the maximum
      uc_nxt = clr_m ? '0 : uc_r + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= CCT_IDLE;
      uc_r <= '0;
      fresh_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      uc_r <= uc_nxt;
      fresh_r <= tick || clr_b || go_count;
    end
  end

  // ****************************************
  // compare registers with buffers
  // ****************************************
  wire direct = !dbuf_r || !counting;
  wire xfer = dbuf_r && mt1;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      buf0_r <= '0;
      buf1_r <= '0;
      cmp0_r <= '0;
      cmp1_r <= '0;
    end else begin
      if (wr_rg0) begin
        buf0_r <= i_wdata[CW-1:0];
      end
      if (wr_rg1) begin
        buf1_r <= i_wdata[CW-1:0];
      end
      if (wr_rg0 && direct) begin
        cmp0_r <= i_wdata[CW-1:0];
      end else if (xfer) begin
        cmp0_r <= buf0_r;
      end
      if (wr_rg1 && direct) begin
        cmp1_r <= i_wdata[CW-1:0];
      end else if (xfer) begin
        cmp1_r <= buf1_r;
      end
    end
  end

  // ****************************************
  // capture control
  // ****************************************
  wire hw_on = en_r && (cpm != `CCT_CPM_OFF);
  wire sw_cap = en_r && wr_mod && !i_wdata[`CCT_B_PCP];
  wire hw0 = hw_on && ((cpm[1:0] == 2'h1 && in_rise) ||
                       (cpm[1:0] == 2'h2 && in_rise) ||
                       (cpm[1:0] == 2'h3 && ff_rise));
  wire hw1 = hw_on && ((cpm[1:0] == 2'h1 && b_rise) ||
                       (cpm[1:0] == 2'h2 && in_fall) ||
                       (cpm[1:0] == 2'h3 && ff_fall));
  wire cap0 = hw0 || sw_cap;
  wire cap1 = hw1;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cp0_r <= '0;
      cp1_r <= '0;
      snap_r <= '0;
    end else begin
      if (cap0) begin
        cp0_r <= uc_r;
      end
      if (cap1) begin
        cp1_r <= uc_r;
      end
      if (rd_uc && counting) begin
        snap_r <= uc_r;
      end
    end
  end

  // ****************************************
  // toggle flip-flop
  // ****************************************
  wire tog = (ffen_r[0] && mt0) ^ (ffen_r[1] && mt1) ^
             (ffen_r[2] && cap0) ^ (ffen_r[3] && cap1);

  always_comb begin
    ff_nxt = ff_r;
    if (wr_ffcr && ff_cmd != `CCT_FF_RD) begin
      // software command wins over a same-cycle event
      unique case (ff_cmd)
        `CCT_FF_INV: ff_nxt = ~ff_r;
        `CCT_FF_SET: ff_nxt = 1'b1;
        `CCT_FF_CLR: ff_nxt = 1'b0;
        default: ff_nxt = ff_r;
      endcase
    end else if (tog) begin
      ff_nxt = ~ff_r;
    end
  end

  // ****************************************
  // control registers and events
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_r <= 1'b0;
      prun_r <= 1'b0;
      crun_r <= 1'b0;
      tsel_r <= 1'b0;
      tedge_r <= 1'b0;
      dbuf_r <= 1'b0;
      mod_r <= `CCT_RST_MOD;
      ffen_r <= `CCT_RST_FFCR;
      im_r <= '0;
      st_r <= '0;
      ff_r <= 1'b0;
      ff_d_r <= 1'b0;
    end else begin
      if (wr_en) begin
        en_r <= i_wdata[`CCT_B_EN];
      end
      if (wr_run) begin
        prun_r <= i_wdata[`CCT_B_PRUN];
        crun_r <= i_wdata[`CCT_B_CRUN];
      end
      if (wr_cr) begin
        tsel_r <= i_wdata[`CCT_B_TSEL];
        tedge_r <= i_wdata[`CCT_B_TEDGE];
        dbuf_r <= i_wdata[`CCT_B_DBUF];
      end
      if (wr_mod) begin
        mod_r <= i_wdata[7:0];
      end
      if (wr_ffcr) begin
        ffen_r <= i_wdata[5:2];
      end
      if (wr_im) begin
        im_r <= i_wdata[2:0];
      end
      // new events win over the read-to-clear
      st_r <= (rd_st ? 3'h0 : st_r) | {of_ev, mt1, mt0};
      ff_r <= ff_nxt;
      ff_d_r <= ff_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  wire mi_nxt = (im_r[2] && of_ev) || (im_r[1] && mt1) ||
                (im_r[0] && mt0);

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mi_r <= 1'b0;
      ci0_r <= 1'b0;
      ci1_r <= 1'b0;
    end else begin
      mi_r <= mi_nxt;
      ci0_r <= cap0;
      ci1_r <= cap1;
    end
  end

  assign o_timer_output_pin = ff_r;
  assign o_match_interrupt = mi_r;
  assign o_capture0_interrupt = ci0_r;
  assign o_capture1_interrupt = ci1_r;

  // ****************************************
  // read path
  // ****************************************
  wire [CW-1:0] uc_view = counting ? uc_r : snap_r;
  wire [31:0] rmux =
    (i_addr == `CCT_A_EN) ? {24'h0, en_r, 7'h0} :
    (i_addr == `CCT_A_RUN) ? {30'h0, prun_r, crun_r} :
    (i_addr == `CCT_A_CR) ? {29'h0, dbuf_r, tedge_r, tsel_r} :
    (i_addr == `CCT_A_MOD) ? {24'h0, mod_r} :
    (i_addr == `CCT_A_FFCR) ? {26'h0, ffen_r, `CCT_FF_RD} :
    (i_addr == `CCT_A_ST) ? {29'h0, st_r} :
    (i_addr == `CCT_A_IM) ? {29'h0, im_r} :
    (i_addr == `CCT_A_UC) ? {16'h0, uc_view} :
    (i_addr == `CCT_A_RG0) ? {16'h0, cmp0_r} :
    (i_addr == `CCT_A_RG1) ? {16'h0, cmp1_r} :
    (i_addr == `CCT_A_CP0) ? {16'h0, cp0_r} :
    (i_addr == `CCT_A_CP1) ? {16'h0, cp1_r} : 32'h0;

  // data stands only in the cycle after the read strobe
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= 32'h0;
    end else if (i_rd) begin
      rdata_r <= rmux;
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign o_rdata = rdata_r;

endmodule

// ===== rtl/cct_params.svh
// constants for the 16-bit compare/capture timer channel
// assumes a 6-bit byte address on the plain register port
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH
// register byte offsets
`define CCT_A_EN 6'h00
`define CCT_A_RUN 6'h04
`define CCT_A_CR 6'h08
`define CCT_A_MOD 6'h0C
`define CCT_A_FFCR 6'h10
`define CCT_A_ST 6'h14
`define CCT_A_IM 6'h18
`define CCT_A_UC 6'h1C
`define CCT_A_RG0 6'h20
`define CCT_A_RG1 6'h24
`define CCT_A_CP0 6'h28
`define CCT_A_CP1 6'h2C
// field positions
`define CCT_B_EN 7
`define CCT_B_PRUN 1
`define CCT_B_CRUN 0
`define CCT_B_TSEL 0
`define CCT_B_TEDGE 1
`define CCT_B_DBUF 2
`define CCT_B_CLE 3
`define CCT_B_PCP 7
`define CCT_B_M0T 2
`define CCT_B_M1T 3
`define CCT_B_C0T 4
`define CCT_B_C1T 5
// field values
`define CCT_CLK_EXT 3'h0
`define CCT_CPM_OFF 3'h0
`define CCT_CPM_CLR0 3'h4
`define CCT_CPM_CLR1 3'h5
`define CCT_FF_INV 2'h0
`define CCT_FF_SET 2'h1
`define CCT_FF_CLR 2'h2
`define CCT_FF_RD 2'h3
// reset values and counter maximum
`define CCT_RST_MOD 8'h80
`define CCT_RST_FFCR 4'h0
`define CCT_UC_MAX 16'hFFFF
`endif

// ===== rtl/cct_pkg.sv
// types for the compare/capture timer channel
// assumes cct_params.svh holds the numeric constants
package cct_pkg;
  typedef enum logic [1:0] {
    CCT_IDLE,
    CCT_WAIT,
    CCT_COUNT
  } cct_state_t;
endpackage

// ===== verif/cct_timer_monitor.sv
// checker for the compare/capture timer channel
// assumes it is bound to cct_timer and sees only that module's ports
`timescale 1ns/1ps
`include "cct_params.svh"
module cct_timer_chk #(
  parameter int CW = 16,
  parameter int PW = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_timer_input_pin,
  input wire logic i_capture_input_b,
  input wire logic o_timer_output_pin,
  input wire logic o_match_interrupt,
  input wire logic o_capture0_interrupt,
  input wire logic o_capture1_interrupt
);
  // ****************************************
  // shadow of the control fields
  // ****************************************
  logic en_r;
  logic [2:0] cpm_r;
  logic [2:0] im_r;
  wire wr_ff = i_wr && (i_addr == `CCT_A_FFCR);
  wire wr_mod = i_wr && (i_addr == `CCT_A_MOD);
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_r <= 1'b0;
      cpm_r <= 3'h0;
      im_r <= 3'h0;
    end else begin
      if (i_wr && (i_addr == `CCT_A_EN)) en_r <= i_wdata[`CCT_B_EN];
      if (wr_mod) cpm_r <= i_wdata[6:4];
      if (i_wr && (i_addr == `CCT_A_IM)) im_r <= i_wdata[2:0];
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  upper_zero_a: assert property (i_rd |=> o_rdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  cmd_reads_a: assert property (i_rd && i_addr == `CCT_A_FFCR |=> o_rdata[1:0] == 2'h3)
    else $error("flop command field not read as ones");
  ff_set_a: assert property (wr_ff && i_wdata[1:0] == `CCT_FF_SET |=>
    o_timer_output_pin)
    else $error("set command did not raise output pin");
  ff_clr_a: assert property (wr_ff && i_wdata[1:0] == `CCT_FF_CLR |=> !o_timer_output_pin)
    else $error("clear command did not lower output pin");
  ff_inv_a: assert property (wr_ff && i_wdata[1:0] == `CCT_FF_INV |=>
    o_timer_output_pin != $past(o_timer_output_pin))
    else $error("invert command left output pin");
  cap1_off_a: assert property (cpm_r == 3'h0 && $past(cpm_r) == 3'h0 &&
    $past(cpm_r, 2) == 3'h0 |-> !o_capture1_interrupt)
    else $error("capture one fired with captures off");
  sw_cap_a: assert property (en_r && wr_mod && !i_wdata[`CCT_B_PCP] |->
    ##[1:3] o_capture0_interrupt)
    else $error("software capture raised no capture zero pulse");
  mask_off_a: assert property (im_r == 3'h0 && $past(im_r) == 3'h0 &&
    $past(im_r, 2) == 3'h0 |-> !o_match_interrupt)
    else $error("match interrupt passed a full mask");
  idle_quiet_a: assert property (!en_r && !$past(en_r) && !$past(en_r, 2) |->
    !o_match_interrupt && !o_capture1_interrupt)
    else $error("disabled channel raised an interrupt");
  cover property (o_match_interrupt);
  cover property (o_capture0_interrupt);
  cover property ($fell(o_timer_output_pin));
endmodule

bind cct_timer cct_timer_chk #(.CW(CW), .PW(PW)) u_chk (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_input_pin(i_timer_input_pin),
  .i_capture_input_b(i_capture_input_b), .o_timer_output_pin(o_timer_output_pin),
  .o_match_interrupt(o_match_interrupt), .o_capture0_interrupt(o_capture0_interrupt),
  .o_capture1_interrupt(o_capture1_interrupt)
);

// ===== verif/cct_pin_model.sv
// external pin source for the timer channel: event clock, trigger, capture
// assumes the caller runs on the same clock; levels held long enough to sync
`timescale 1ns/1ps
module cct_pin_model (
  input wire logic i_ref_clk,
  output logic o_timer_input_pin,
  output logic o_capture_input_b
);
  initial begin
    o_timer_input_pin = 1'b0;
    o_capture_input_b = 1'b0;
  end
  // low time of 6 clocks leaves the 3-flop synchroniser room to settle
  task automatic pulse(input bit b, input int n, input int hi);
    for (int k = 0; k < n; k++) begin
      @(posedge i_ref_clk);
      if (b) o_capture_input_b <= 1'b1;
      else o_timer_input_pin <= 1'b1;
      repeat (hi) @(posedge i_ref_clk);
      if (b) o_capture_input_b <= 1'b0;
      else o_timer_input_pin <= 1'b0;
      repeat (6) @(posedge i_ref_clk);
    end
  endtask
endmodule

// ===== verif/testbench.sv
// self-checking bench for the compare/capture timer channel
// assumes 50 MHz clock and the register map of cct_params.svh
`timescale 1ns/1ps
`include "cct_params.svh"
module testbench;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [5:0] i_addr = 6'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic tpin, bpin, opin, mirq, c0irq, c1irq;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int m_n = 0;
  int c0_n = 0;
  int c1_n = 0;
  int mt_last = 0;
  int mt_prev = 0;
  int unsigned taps[8] = '{0, 1, 4, 16, 32, 64, 128, 256};
  logic [5:0] ra[11] = '{`CCT_A_EN, `CCT_A_RUN, `CCT_A_CR, `CCT_A_MOD, `CCT_A_FFCR,
    `CCT_A_ST, `CCT_A_IM, `CCT_A_RG0, `CCT_A_RG1, 6'h30, 6'h3D};
  logic [31:0] rv[11] = '{32'h0, 32'h0, 32'h0, 32'h80, 32'h3, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0};
  logic [1:0] ffc[4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  logic ffe[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #10 i_ref_clk = ~i_ref_clk;
  cct_timer #(.CW(16), .PW(8)) DUT (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_input_pin(tpin),
    .i_capture_input_b(bpin), .o_timer_output_pin(opin), .o_match_interrupt(mirq),
    .o_capture0_interrupt(c0irq), .o_capture1_interrupt(c1irq)
  );
  cct_pin_model pins (
    .i_ref_clk(i_ref_clk), .o_timer_input_pin(tpin), .o_capture_input_b(bpin)
  );
  // ****************************************
  // bus, checks, expectations
  // ****************************************
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitm(input int k, input int lim);
    int s;
    s = m_n;
    repeat (lim) begin
      if (m_n >= s + k) break;
      @(posedge i_ref_clk);
    end
  endtask
  // compare one plus the zero state sets the period, scaled by the tap
  function automatic int unsigned period(input int s, input int unsigned n);
    return (n + 1) * taps[s];
  endfunction
  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (mirq === 1'b1) begin
      mt_prev = mt_last;
      mt_last = cyc;
      m_n++;
    end
    if (c0irq === 1'b1) c0_n++;
    if (c1irq === 1'b1) c1_n++;
    if (cyc == 90000) begin
      num_errors++;
      conclude();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [31:0] v;
    int unsigned n, a, b, k;
    int s0;
    void'($urandom(19));
    repeat (3) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(ra[i], v);
      chk(v, rv[i]);
    end
    wr(`CCT_A_MOD, 32'h81);
    wr(`CCT_A_RUN, 32'h3);
    repeat (20) @(posedge i_ref_clk);
    rd(`CCT_A_UC, v);
    chk(v, 32'h0);
    wr(`CCT_A_RUN, 32'h0);
    wr(`CCT_A_EN, 32'h80);
    for (int i = 0; i < 4; i++) begin
      wr(`CCT_A_FFCR, {30'h0, ffc[i]});
      @(posedge i_ref_clk);
      chk({31'h0, opin}, {31'h0, ffe[i]});
    end
    // stopped writes with double buffering on must still land directly
    for (int s = 1; s < 8; s++) begin
      n = 1 + $urandom % 3;
      wr(`CCT_A_CR, 32'h4);
      wr(`CCT_A_RG1, 32'(n));
      wr(`CCT_A_MOD, 32'h88 | 32'(s));
      wr(`CCT_A_IM, 32'h2);
      wr(`CCT_A_RUN, 32'h3);
      waitm(3, 4000);
      chk(32'(mt_last - mt_prev), period(s, n));
      wr(`CCT_A_RUN, 32'h0);
    end
    wr(`CCT_A_IM, 32'h0);
    wr(`CCT_A_MOD, 32'h89);
    wr(`CCT_A_RUN, 32'h3);
    s0 = m_n;
    repeat (50) @(posedge i_ref_clk);
    chk(32'(m_n - s0), 32'h0);
    rd(`CCT_A_ST, v);
    chk({31'h0, v[1]}, 32'h1);
    wr(`CCT_A_RUN, 32'h0);
    a = 2 + $urandom % 20;
    b = a + 1 + $urandom % 20;
    wr(`CCT_A_RG0, 32'(a));
    wr(`CCT_A_RG1, 32'(b));
    wr(`CCT_A_FFCR, 32'hE);
    wr(`CCT_A_RUN, 32'h3);
    k = 0;
    repeat (300) if (opin !== 1'b1) @(posedge i_ref_clk) #1;
    while (opin === 1'b1 && k < 300) begin
      @(posedge i_ref_clk) #1;
      k++;
    end
    chk(32'(k), 32'(b - a));
    // running with buffering on: a new period waits for the compare-one match
    n = b + 1 + $urandom % 8;
    wr(`CCT_A_RG1, 32'(n));
    rd(`CCT_A_RG1, v);
    chk(v, 32'(b));
    repeat (60) @(posedge i_ref_clk);
    rd(`CCT_A_RG1, v);
    chk(v, 32'(n));
    wr(`CCT_A_FFCR, 32'h2);
    wr(`CCT_A_RUN, 32'h0);
    wr(`CCT_A_CR, 32'h0);
    wr(`CCT_A_MOD, 32'h80);
    wr(`CCT_A_RUN, 32'h3);
    k = 1 + $urandom % 8;
    pins.pulse(1'b0, k, 4);
    rd(`CCT_A_UC, v);
    chk(v, 32'(k));
    s0 = c1_n;
    pins.pulse(1'b1, 1, 4);
    rd(`CCT_A_UC, v);
    chk(v, 32'(k));
    wr(`CCT_A_MOD, 32'hD0);
    pins.pulse(1'b1, 1, 4);
    rd(`CCT_A_UC, v);
    chk(v, 32'h0);
    chk(32'(c1_n - s0), 32'h1);
    pins.pulse(1'b0, k, 4);
    rd(`CCT_A_UC, v);
    wr(`CCT_A_RUN, 32'h0);
    rd(`CCT_A_UC, v);
    chk(v, 32'(k));
    s0 = c0_n;
    wr(`CCT_A_MOD, 32'h40);
    repeat (3) @(posedge i_ref_clk);
    chk(32'(c0_n - s0), 32'h1);
    rd(`CCT_A_CP0, v);
    chk(v, 32'h0);
    // capture mode 010: pin high time is the gap between the two captures
    a = 5 + $urandom % 20;
    s0 = c1_n;
    wr(`CCT_A_MOD, 32'hA1);
    wr(`CCT_A_FFCR, 32'h12);
    wr(`CCT_A_RUN, 32'h3);
    pins.pulse(1'b0, 1, a);
    rd(`CCT_A_CP0, v);
    n = v;
    rd(`CCT_A_CP1, v);
    chk(v - 32'(n), 32'(a));
    chk(32'(c1_n - s0), 32'h1);
    chk({31'h0, opin}, 32'h1);
    wr(`CCT_A_FFCR, 32'h2);
    wr(`CCT_A_RUN, 32'h0);
    wr(`CCT_A_MOD, 32'h81);
    wr(`CCT_A_CR, 32'h1);
    wr(`CCT_A_RUN, 32'h3);
    repeat (20) @(posedge i_ref_clk);
    rd(`CCT_A_UC, v);
    // still waiting, so the snapshot holds the last count read while running
    chk(v, 32'(k));
    // long high level separates a rising start from a falling one
    pins.pulse(1'b0, 1, 40);
    rd(`CCT_A_UC, v);
    chk({31'h0, v > 32'd30}, 32'h1);
    wr(`CCT_A_RUN, 32'h0);
    wr(`CCT_A_CR, 32'h0);
    wr(`CCT_A_IM, 32'h4);
    wr(`CCT_A_RUN, 32'h3);
    waitm(1, 70000);
    rd(`CCT_A_ST, v);
    chk({31'h0, v[2]}, 32'h1);
    rd(`CCT_A_ST, v);
    chk({31'h0, v[2]}, 32'h0);
    conclude();
  end
endmodule
